// File: common/flash_host_pkg.sv
// constants, types and pin bundle for the flash command host
package flash_host_pkg;

  // register port
  localparam int REG_AW = 4;    // register address width
  localparam int REG_DW = 32;   // register data width
  localparam logic [3:0] REG_CTRL  = 4'h0;  // pin control
  localparam logic [3:0] REG_OP    = 4'h1;  // operation start
  localparam logic [3:0] REG_ADDR  = 4'h2;  // target word address
  localparam logic [3:0] REG_DATA  = 4'h3;  // program word
  localparam logic [3:0] REG_STAT  = 4'h4;  // status, write one clears
  localparam logic [3:0] REG_RWORD = 4'h5;  // last word read from flash

  // field positions
  localparam int CTRL_RP_BIT  = 0;  // release power-down
  localparam int CTRL_WP_BIT  = 1;  // write-protect pin level
  localparam int ST_BUSY_BIT  = 0;  // sequencer active
  localparam int ST_RDY_BIT   = 1;  // ready/busy pin level
  localparam int ST_WANT_BIT  = 2;  // page word wanted
  localparam int ST_REF_BIT   = 3;  // operation refused (sticky)
  localparam int ST_FERR_BIT  = 4;  // flash error seen (sticky)

  // flash geometry
  localparam int FA_W = 20;                    // word address width
  localparam int FD_W = 16;                    // data bus width
  localparam logic [7:0] PAGE_WORDS = 8'h80;   // words per page
  localparam logic [15:0] ABORT_WORD = 16'h00B0; // locked-block abort

  // timing at 125 MHz
  localparam int CLK_NS  = 8;
  localparam int T_ACC_NS = 90;  // read access time
  localparam int T_WE_NS  = 50;  // write pulse width
  localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WE_CYC  = 4'((T_WE_NS + CLK_NS - 1) / CLK_NS);

  // flash command opcodes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_IDENT      = 8'h90;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] CMD_WORD_PROG  = 8'h40;
  localparam logic [7:0] CMD_PAGE_PROG  = 8'h41;
  localparam logic [7:0] CMD_LOAD_BUF   = 8'h74;
  localparam logic [7:0] CMD_BUF_FLASH  = 8'h0E;
  localparam logic [7:0] CMD_ERASE      = 8'h20;
  localparam logic [7:0] CMD_SUSPEND    = 8'hB0;
  localparam logic [7:0] CMD_CONFIRM    = 8'hD0;
  localparam logic [7:0] CMD_READ_LOCK  = 8'h71;
  localparam logic [7:0] CMD_LOCK       = 8'h77;
  localparam logic [7:0] CMD_ERASE_ALL  = 8'hA7;

  // operations software can start
  typedef enum logic [3:0] {
    OP_READ_ARRAY = 4'b0000,
    OP_IDENT      = 4'b0001,
    OP_STATUS     = 4'b0010,
    OP_CLR_STATUS = 4'b0011,
    OP_WORD_PROG  = 4'b0100,
    OP_PAGE_PROG  = 4'b0101,
    OP_LOAD_BUF   = 4'b0110,
    OP_BUF_FLASH  = 4'b0111,
    OP_ERASE      = 4'b1000,
    OP_SUSPEND    = 4'b1001,
    OP_RESUME     = 4'b1010,
    OP_READ_LOCK  = 4'b1011,
    OP_LOCK       = 4'b1100,
    OP_ERASE_ALL  = 4'b1101,
    OP_READ_WORD  = 4'b1110,
    OP_RECOVER    = 4'b1111
  } op_t;

  // what follows the opcode cycle
  typedef enum logic [2:0] {
    T_NONE    = 3'b000,
    T_READ    = 3'b001,
    T_DATA    = 3'b010,
    T_CONFIRM = 3'b011,
    T_PAGE    = 3'b100,
    T_ARRAY   = 3'b101
  } tail_t;

  // flash pin outputs
  typedef struct packed {
    logic            ce_n;   // chip enable
    logic            oe_n;   // output enable
    logic            we_n;   // write enable
    logic            reset_powerdown_n;
    logic            wp_n;   // write protect
    logic [FA_W-1:0] addr;   // word address
    logic [FD_W-1:0] dq;     // data out
    logic            dq_oe;  // data bus driven
  } flash_pins_t;

endpackage : flash_host_pkg

// File: hdl/flash_cmd_host.sv
// host-side sequencer that drives the flash command interface pins
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host #(
  parameter logic [2:0] BANK1_CODE = 3'h0  // A19-A17 of first bank
) (
  // clock and reset
  input  wire logic                            core_clk_i,
  input  wire logic                            reset_i,
  // register port
  input  wire logic [flash_host_pkg::REG_AW-1:0] reg_addr_i,
  input  wire logic [flash_host_pkg::REG_DW-1:0] reg_wdata_i,
  input  wire logic                            reg_wr_i,
  input  wire logic                            reg_rd_i,
  output logic      [flash_host_pkg::REG_DW-1:0] reg_rdata_o,
  // flash pins
  output flash_host_pkg::flash_pins_t          flash_o,
  input  wire logic [flash_host_pkg::FD_W-1:0] dq_i,
  input  wire logic                            ready_busy_n_i
);
  import flash_host_pkg::*;

  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SETUP = 3'b001,
    S_PULSE = 3'b010,
    S_HOLD  = 3'b011,
    S_REL   = 3'b100,
    S_WAIT  = 3'b101
  } state_t;

  // opcode of each operation
  function automatic logic [7:0] op_code(input op_t o);
    case (o)
      OP_IDENT:      op_code = CMD_IDENT;
      OP_STATUS:     op_code = CMD_STATUS;
      OP_CLR_STATUS: op_code = CMD_CLR_STATUS;
      OP_RECOVER:    op_code = CMD_CLR_STATUS;
      OP_WORD_PROG:  op_code = CMD_WORD_PROG;
      OP_PAGE_PROG:  op_code = CMD_PAGE_PROG;
      OP_LOAD_BUF:   op_code = CMD_LOAD_BUF;
      OP_BUF_FLASH:  op_code = CMD_BUF_FLASH;
      OP_ERASE:      op_code = CMD_ERASE;
      OP_SUSPEND:    op_code = CMD_SUSPEND;
      OP_RESUME:     op_code = CMD_CONFIRM;
      OP_READ_LOCK:  op_code = CMD_READ_LOCK;
      OP_LOCK:       op_code = CMD_LOCK;
      OP_ERASE_ALL:  op_code = CMD_ERASE_ALL;
      default:       op_code = CMD_READ_ARRAY;
    endcase
  endfunction : op_code

  // cycles after the opcode
  function automatic tail_t op_tail(input op_t o);
    case (o)
      OP_IDENT, OP_STATUS, OP_READ_LOCK: op_tail = T_READ;
      OP_WORD_PROG, OP_LOAD_BUF:         op_tail = T_DATA;
      OP_BUF_FLASH, OP_ERASE, OP_LOCK,
      OP_ERASE_ALL:                      op_tail = T_CONFIRM;
      OP_PAGE_PROG:                      op_tail = T_PAGE;
      OP_RECOVER:                        op_tail = T_ARRAY;
      default:                           op_tail = T_NONE;
    endcase
  endfunction : op_tail

  // state registers
  state_t          st_q, st_d;        // sequencer state
  op_t             op_q, op_d;        // active operation
  logic            step_q, step_d;    // 0 opcode, 1 later cycles
  logic            rd_q, rd_d;        // current cycle is a read
  logic [3:0]      cyc_q, cyc_d;      // pulse countdown
  logic [7:0]      cnt_q, cnt_d;      // page words sent
  logic [FA_W-1:0] addr_q, addr_d;    // target address
  logic [FD_W-1:0] data_q, data_d;    // program word
  logic            dok_q, dok_d;      // program word fresh
  logic [FD_W-1:0] rword_q, rword_d;  // last word read
  logic            rp_req_q, rp_req_d;  // requested power-down pin
  logic            wp_req_q, wp_req_d;  // requested protect pin
  logic            ref_q, ref_d;      // refused flag
  logic            ferr_q, ferr_d;    // flash error flag
  flash_pins_t     pins_q, pins_d;    // pin drivers
  logic [REG_DW-1:0] rdata_q, rdata_d;  // register read data

  // launch request for one bus cycle
  logic            go;
  logic            go_rd;
  logic [FA_W-1:0] go_addr;
  logic [FD_W-1:0] go_dq;
  tail_t           tail;
  logic            start;
  logic            bank1_only;

  assign tail  = op_tail(op_q);
  assign start = reg_wr_i && (reg_addr_i == REG_OP);
  // check uses the bank field of the target
  assign bank1_only = (op_t'(reg_wdata_i[3:0]) == OP_WORD_PROG)
                   || (op_t'(reg_wdata_i[3:0]) == OP_LOAD_BUF)
                   || (op_t'(reg_wdata_i[3:0]) == OP_BUF_FLASH);

  // next values of all state
  always_comb
  begin
    st_d     = st_q;
    op_d     = op_q;
    step_d   = step_q;
    rd_d     = rd_q;
    cyc_d    = cyc_q;
    cnt_d    = cnt_q;
    addr_d   = addr_q;
    data_d   = data_q;
    dok_d    = dok_q;
    rword_d  = rword_q;
    rp_req_d = rp_req_q;
    wp_req_d = wp_req_q;
    ref_d    = ref_q;
    ferr_d   = ferr_q;
    pins_d   = pins_q;
    rdata_d  = '0;
    go       = 1'b0;
    go_rd    = 1'b0;
    go_addr  = addr_q;
    go_dq    = '0;
    // power-down pin follows software at once
    pins_d.reset_powerdown_n = rp_req_q;
    // protect pin only moves while flash is idle
    if (st_q == S_IDLE && ready_busy_n_i)
    begin
      pins_d.wp_n = wp_req_q;
    end
    case (st_q)
      S_IDLE:
      begin
        if (start)
        begin
          // deep power-down or wrong bank refuses
          if (!rp_req_q)
          begin
            ref_d = 1'b1;
          end
          else if (bank1_only && addr_q[19:17] != BANK1_CODE)
          begin
            ref_d = 1'b1;
          end
          else
          begin
            op_d  = op_t'(reg_wdata_i[3:0]);
            cnt_d = '0;
            // page program never reuses a word left from an earlier op
            dok_d = 1'b0;
            go    = 1'b1;
            if (op_t'(reg_wdata_i[3:0]) == OP_READ_WORD)
            begin
              step_d = 1'b1;
              go_rd  = 1'b1;
            end
            else
            begin
              step_d = 1'b0;
              // command word, upper byte zero
              go_dq = {8'h00, op_code(op_t'(reg_wdata_i[3:0]))};
            end
          end
        end
      end
      S_SETUP:
      begin
        // strobe the cycle
        pins_d.we_n = rd_q;
        pins_d.oe_n = !rd_q;
        cyc_d = rd_q ? ACC_CYC - 4'h1 : WE_CYC - 4'h1;
        st_d  = S_PULSE;
      end
      S_PULSE:
      begin
        if (cyc_q == 4'h0)
        begin
          pins_d.we_n = 1'b1;
          pins_d.oe_n = 1'b1;
          st_d = S_HOLD;
          if (rd_q)
          begin
            rword_d = dq_i;
            // error or abort seen in a status read
            if (op_q == OP_STATUS && dq_i[5:3] != 3'h0)
            begin
              ferr_d = 1'b1;
            end
          end
        end
        else
        begin
          cyc_d = cyc_q - 4'h1;
        end
      end
      S_HOLD:
      begin
        // end of cycle, bus released
        pins_d.ce_n  = 1'b1;
        pins_d.dq_oe = 1'b0;
        st_d = S_REL;
      end
      S_REL:
      begin
        if (!step_q && tail != T_NONE)
        begin
          step_d = 1'b1;
          go     = (tail != T_PAGE);
          st_d   = (tail == T_PAGE) ? S_WAIT : S_IDLE;
          case (tail)
            T_READ:    go_rd = 1'b1;
            T_DATA:    go_dq = data_q;
            T_CONFIRM: go_dq = {8'h00, CMD_CONFIRM};
            T_ARRAY:   go_dq = {8'h00, CMD_READ_ARRAY};
            default:   go_dq = '0;
          endcase
        end
        else if (tail == T_PAGE && cnt_q != PAGE_WORDS)
        begin
          st_d = S_WAIT;
        end
        else
        begin
          st_d = S_IDLE;
        end
      end
      S_WAIT:
      begin
        // next page word once software supplies it
        if (dok_q)
        begin
          go      = 1'b1;
          dok_d   = 1'b0;
          go_addr = {addr_q[19:7], cnt_q[6:0]};
          go_dq   = data_q;
          cnt_d   = cnt_q + 8'h01;
        end
      end
      default:
      begin
        st_d = S_IDLE;
      end
    endcase
    // drive address and data for a new cycle
    if (go)
    begin
      st_d         = S_SETUP;
      rd_d         = go_rd;
      pins_d.ce_n  = 1'b0;
      pins_d.addr  = go_addr;
      pins_d.dq    = go_dq;
      pins_d.dq_oe = !go_rd;
    end
    // register writes; sets after clears
    if (reg_wr_i)
    begin
      if (reg_addr_i == REG_CTRL)
      begin
        rp_req_d = reg_wdata_i[CTRL_RP_BIT];
        wp_req_d = reg_wdata_i[CTRL_WP_BIT];
      end
      else if (reg_addr_i == REG_ADDR)
      begin
        addr_d = reg_wdata_i[FA_W-1:0];
      end
      else if (reg_addr_i == REG_DATA)
      begin
        data_d = reg_wdata_i[FD_W-1:0];
        dok_d  = 1'b1;
      end
      else if (reg_addr_i == REG_STAT)
      begin
        ref_d  = ref_q & !reg_wdata_i[ST_REF_BIT];
        ferr_d = ferr_q & !reg_wdata_i[ST_FERR_BIT];
      end
      else if (start && st_q != S_IDLE)
      begin
        ref_d = 1'b1;  // busy start refused
      end
    end
    // a flag raised this cycle survives its clear
    if (ref_q == 1'b0 && ref_d == 1'b0 && start)
    begin
      ref_d = (st_q != S_IDLE) || (st_q == S_IDLE && !rp_req_q)
           || (st_q == S_IDLE && bank1_only
               && addr_q[19:17] != BANK1_CODE);
    end
    if (st_q == S_PULSE && cyc_q == 4'h0 && rd_q
        && op_q == OP_STATUS && dq_i[5:3] != 3'h0)
    begin
      ferr_d = 1'b1;
    end
    // register reads, data next cycle only
    if (reg_rd_i)
    begin
      if (reg_addr_i == REG_CTRL)
      begin
        rdata_d[CTRL_RP_BIT] = rp_req_q;
        rdata_d[CTRL_WP_BIT] = wp_req_q;
      end
      else if (reg_addr_i == REG_ADDR)
      begin
        rdata_d[FA_W-1:0] = addr_q;
      end
      else if (reg_addr_i == REG_DATA)
      begin
        rdata_d[FD_W-1:0] = data_q;
      end
      else if (reg_addr_i == REG_STAT)
      begin
        rdata_d[ST_BUSY_BIT] = (st_q != S_IDLE);
        rdata_d[ST_RDY_BIT]  = ready_busy_n_i;
        rdata_d[ST_WANT_BIT] = (st_q == S_WAIT) && !dok_q;
        rdata_d[ST_REF_BIT]  = ref_q;
        rdata_d[ST_FERR_BIT] = ferr_q;
      end
      else if (reg_addr_i == REG_RWORD)
      begin
        rdata_d[FD_W-1:0] = rword_q;
      end
    end
  end

  // register all state
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      st_q     <= S_IDLE;
      op_q     <= OP_READ_ARRAY;
      step_q   <= 1'b0;
      rd_q     <= 1'b0;
      cyc_q    <= 4'h0;
      cnt_q    <= 8'h00;
      addr_q   <= '0;
      data_q   <= '0;
      dok_q    <= 1'b0;
      rword_q  <= '0;
      rp_req_q <= 1'b0;
      wp_req_q <= 1'b0;
      ref_q    <= 1'b0;
      ferr_q   <= 1'b0;
      pins_q   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                    reset_powerdown_n: 1'b0, wp_n: 1'b0,
                    addr: '0, dq: '0, dq_oe: 1'b0};
      rdata_q  <= '0;
    end
    else
    begin
      st_q     <= st_d;
      op_q     <= op_d;
      step_q   <= step_d;
      rd_q     <= rd_d;
      cyc_q    <= cyc_d;
      cnt_q    <= cnt_d;
      addr_q   <= addr_d;
      data_q   <= data_d;
      dok_q    <= dok_d;
      rword_q  <= rword_d;
      rp_req_q <= rp_req_d;
      wp_req_q <= wp_req_d;
      ref_q    <= ref_d;
      ferr_q   <= ferr_d;
      pins_q   <= pins_d;
      rdata_q  <= rdata_d;
    end
  end

  assign flash_o     = pins_q;
  assign reg_rdata_o = rdata_q;

  // strobes only inside chip enable
  a_strobe_in_ce: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    (!pins_q.we_n || !pins_q.oe_n) |-> !pins_q.ce_n)
    else $error("strobe outside chip enable");

  // never read and write together
  a_oe_we_excl: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    !(!pins_q.we_n && !pins_q.oe_n) && !(!pins_q.oe_n && pins_q.dq_oe))
    else $error("read and write strobes overlap");

  // write pulse lasts seven cycles
  a_we_width: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    $fell(pins_q.we_n) |-> !pins_q.we_n [*7] ##1 pins_q.we_n)
    else $error("write pulse width wrong");

  // first-bank commands aimed at first bank
  a_bank1_cmd: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    ($fell(pins_q.we_n) && (op_q == OP_WORD_PROG
      || op_q == OP_LOAD_BUF || op_q == OP_BUF_FLASH))
    |-> pins_q.addr[19:17] == BANK1_CODE)
    else $error("first-bank command off bank");

  // page words ascend with held upper bits
  a_page_order: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    ($fell(pins_q.we_n) && op_q == OP_PAGE_PROG && step_q)
    |-> pins_q.addr[6:0] == 7'($past(cnt_q, 2))
        && pins_q.addr[19:7] == addr_q[19:7])
    else $error("page word address out of order");

  // second cycle of confirm commands carries D0H
  a_confirm_d0: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    ($fell(pins_q.we_n) && step_q && tail == T_CONFIRM)
    |-> pins_q.dq == {8'h00, CMD_CONFIRM})
    else $error("confirm cycle data wrong");

  // recovery ends with array read command
  a_recover_ff: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    ($fell(pins_q.we_n) && step_q && op_q == OP_RECOVER)
    |-> pins_q.dq == {8'h00, CMD_READ_ARRAY})
    else $error("recovery second cycle not FFH");

  // protect pin frozen while flash busy
  a_wp_steady: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    (!ready_busy_n_i || st_q != S_IDLE) |=> $stable(pins_q.wp_n))
    else $error("protect pin moved while busy");

  // status read stays in the commanded bank
  a_status_bank: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    ($fell(pins_q.oe_n) && op_q == OP_STATUS)
    |-> step_q && pins_q.addr == addr_q)
    else $error("status read at wrong address");

  // start in power-down refused next cycle
  a_pd_refuse: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    (start && st_q == S_IDLE && !rp_req_q) |=> ref_q && st_q == S_IDLE)
    else $error("start in power-down not refused");

endmodule : flash_cmd_host
`default_nettype wire

// File: sim/flash_dev_model.sv
// behavioural flash device answering the host's bus cycles
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] MFR_ID   = 8'h5A,  // arbitrary value
  parameter logic [7:0] DEV_ID   = 8'h3C,  // arbitrary value
  parameter int         BUSY_CYC = 200     // cycles of one operation
) (
  // pins from the host
  input  wire logic                        core_clk_i,
  input  wire flash_host_pkg::flash_pins_t pins_i,
  // answers to the host
  output logic      [15:0]                 dq_o,
  output logic                             ready_busy_n_o,
  // observation for the bench
  output logic      [7:0]                  first_cmd_o,
  output logic      [7:0]                  page_cnt_o,
  output logic                             proto_err_o
);
  import flash_host_pkg::*;
  logic [7:0]  mode_q = 8'hFF;  // current read mode
  logic [7:0]  pend_q = 8'h00;  // command awaiting its data cycle
  logic [7:0]  sr_q   = 8'h00;  // status flags below ready
  logic [63:0] lock_q = '1;     // lock bit per 16K block, 1 unlocked
  logic [19:0] addr_q = '0;     // address of the opcode cycle
  int          busy_q = 0;      // remaining busy cycles
  logic        we_q   = 1'b1;   // write strobe one cycle ago
  logic        wp_q   = 1'b0;   // write-protect one cycle ago
  logic [15:0] last_q = '0;     // last level driven on dq
  logic [15:0] rd_val;          // word the read mode presents
  logic        prot;            // addressed block protected
  logic [7:0]  cmd;             // command byte
  logic [5:0]  blk;             // addressed block
  assign cmd = pins_i.dq[7:0];
  assign blk = pins_i.addr[19:14];
  // boot block guarded by wp alone, others by their lock bit too
  assign prot = !pins_i.reset_powerdown_n || (!pins_i.wp_n
    && (blk == 6'h00 || !lock_q[blk]));
  // word presented during a read cycle
  always_comb
  begin
    case (mode_q)
      8'h70:   rd_val = {8'h00, busy_q == 0, sr_q[6:0]};
      8'h90:   rd_val = {8'h00, pins_i.addr[0] ? DEV_ID : MFR_ID};
      8'h71:   rd_val = {9'h000, lock_q[blk], 6'h00};
      default: rd_val = pins_i.addr[15:0] ^ 16'hA5A5;  // array word
    endcase
  end
  // released bus shows no stale value, ready line driven low while busy
  assign dq_o = (!pins_i.ce_n && !pins_i.oe_n && pins_i.reset_powerdown_n)
    ? rd_val : ~last_q;
  assign ready_busy_n_o = (busy_q == 0);
  // command decoding on the closing edge of each write pulse
  always_ff @(posedge core_clk_i)
  begin
    we_q <= pins_i.we_n;
    wp_q <= pins_i.wp_n;
    if (busy_q != 0)
      busy_q <= busy_q - 1;
    if (!pins_i.ce_n && !pins_i.oe_n)
      last_q <= dq_o;
    if (busy_q != 0 && pins_i.wp_n != wp_q)
      proto_err_o <= 1'b1;
    if (!pins_i.reset_powerdown_n)
    begin
      mode_q <= 8'hFF;
      pend_q <= 8'h00;
      page_cnt_o <= 8'h00;
      proto_err_o <= 1'b0;
    end
    else if (pins_i.we_n && !we_q && !pins_i.ce_n)
    begin
      if (pend_q == 8'h41)
      begin
        if (pins_i.addr[6:0] != page_cnt_o[6:0]
            || pins_i.addr[19:7] != addr_q[19:7])
          proto_err_o <= 1'b1;
        page_cnt_o <= page_cnt_o + 8'h01;
        if (page_cnt_o == 8'h7F)
        begin
          pend_q <= 8'h00;
          busy_q <= BUSY_CYC;
        end
      end
      else if (pend_q != 8'h00)
      begin
        pend_q <= 8'h00;
        mode_q <= 8'h70;
        if ((pend_q == 8'h77) ? !pins_i.wp_n
            : (prot && pend_q inside {8'h20, 8'h40}))
          sr_q <= 8'hB0;
        else if (pend_q == 8'h77)
          lock_q[blk] <= 1'b0;
        else
          busy_q <= BUSY_CYC;
      end
      else
      begin
        first_cmd_o <= cmd;
        addr_q <= pins_i.addr;
        page_cnt_o <= 8'h00;
        if (cmd inside {8'h40, 8'h41, 8'h74, 8'h0E, 8'h20, 8'h77, 8'hA7})
          pend_q <= cmd;
        else if (cmd == 8'h50)
          sr_q <= 8'h00;
        else if (cmd == 8'hB0 || cmd == 8'hD0)
          sr_q[6] <= (cmd == 8'hB0);
        else
          mode_q <= cmd;
      end
    end
  end
endmodule : flash_dev_model
`default_nettype wire

// File: sim/tb_flash_cmd_host.sv
// self-checking bench for the flash command host
`timescale 1ns/1ps
`default_nettype none
module tb_flash_cmd_host;
  import flash_host_pkg::*;
  logic        core_clk  = 1'b0;  // 125 MHz clock
  logic        reset     = 1'b1;  // synchronous reset
  logic [3:0]  reg_addr  = 4'h0;  // register index
  logic [31:0] reg_wdata = '0;    // register write data
  logic        reg_wr    = 1'b0;  // write strobe
  logic        reg_rd    = 1'b0;  // read strobe
  logic [31:0] reg_rdata;         // register read data
  flash_pins_t pins;              // pins toward the flash
  logic [15:0] dq;                // flash data bus
  logic        ready_busy_n;      // flash ready line
  logic [7:0]  first_cmd;         // last opcode seen by the flash
  logic [7:0]  page_cnt;          // words of the last page
  logic        proto_err;         // flash saw a bad sequence
  logic [31:0] rv;                // scratch read value
  int          num_errors = 0;
  int          checks     = 0;
  int          cycles     = 0;
  flash_cmd_host dut (.core_clk_i(core_clk), .reset_i(reset),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .flash_o(pins),
    .dq_i(dq), .ready_busy_n_i(ready_busy_n));
  flash_dev_model model (.core_clk_i(core_clk), .pins_i(pins),
    .dq_o(dq), .ready_busy_n_o(ready_busy_n), .first_cmd_o(first_cmd),
    .page_cnt_o(page_cnt), .proto_err_o(proto_err));
  initial forever #4 core_clk = ~core_clk;
  // hang guard
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 60000)
    begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd_reg
  // poll status until the given bit shows the given level
  task automatic poll(input int b, input logic lvl);
    int n;
    n = 0;
    rd_reg(REG_STAT, rv);
    while (rv[b] !== lvl && n < 3000)
    begin
      rd_reg(REG_STAT, rv);
      n++;
    end
    chk({31'h0, rv[b]}, {31'h0, lvl});
  endtask : poll
  task automatic run_op(input logic [19:0] a, input logic [3:0] op);
    wr_reg(REG_ADDR, {12'h000, a});
    wr_reg(REG_OP, {28'h0000000, op});
    poll(ST_BUSY_BIT, 1'b0);
  endtask : run_op
  task automatic word_is(input logic [19:0] a, input logic [3:0] op,
                         input logic [15:0] exp);
    run_op(a, op);
    rd_reg(REG_RWORD, rv);
    chk(rv, {16'h0000, exp});
  endtask : word_is
  task automatic stat_bit(input int b, input logic exp);
    rd_reg(REG_STAT, rv);
    chk({31'h0, rv[b]}, {31'h0, exp});
  endtask : stat_bit
  task automatic t_reset();
    chk({29'h0, pins.ce_n, pins.we_n, pins.reset_powerdown_n}, 32'h6);
    rd_reg(4'hF, rv);
    chk(rv, 32'h0);
    run_op(20'h00000, OP_STATUS);
    stat_bit(ST_REF_BIT, 1'b1);
    wr_reg(REG_STAT, 32'h8);
    stat_bit(ST_REF_BIT, 1'b0);
  endtask : t_reset
  task automatic t_ident();
    wr_reg(REG_CTRL, 32'h3);
    word_is(20'h00000, OP_IDENT, 16'h005A);
    word_is(20'h00001, OP_IDENT, 16'h003C);
    word_is(20'h00000, OP_STATUS, 16'h0080);
  endtask : t_ident
  task automatic t_refuse();
    run_op(20'h80000, OP_WORD_PROG);
    stat_bit(ST_REF_BIT, 1'b1);
    wr_reg(REG_STAT, 32'h8);
    run_op(20'hE0000, OP_BUF_FLASH);
    stat_bit(ST_REF_BIT, 1'b1);
    wr_reg(REG_STAT, 32'h8);
  endtask : t_refuse
  task automatic t_erase();
    run_op(20'h08000, OP_ERASE);
    stat_bit(ST_RDY_BIT, 1'b0);
    word_is(20'h08000, OP_STATUS, 16'h0000);
    repeat (300) @(posedge core_clk);
    stat_bit(ST_RDY_BIT, 1'b1);
  endtask : t_erase
  task automatic t_lock();
    run_op(20'h04000, OP_LOCK);
    word_is(20'h04000, OP_READ_LOCK, 16'h0000);
    word_is(20'h08000, OP_READ_LOCK, 16'h0040);
    wr_reg(REG_CTRL, 32'h1);
    run_op(20'h04000, OP_ERASE);
    word_is(20'h04000, OP_STATUS, ABORT_WORD);
    stat_bit(ST_FERR_BIT, 1'b1);
    wr_reg(REG_STAT, 32'h10);
    run_op(20'h04000, OP_RECOVER);
    word_is(20'h04000, OP_READ_WORD, 16'hE5A5);
    wr_reg(REG_CTRL, 32'h3);
  endtask : t_lock
  task automatic t_page();
    wr_reg(REG_ADDR, 32'h00380);
    wr_reg(REG_OP, {28'h0000000, OP_PAGE_PROG});
    for (int i = 0; i < 128; i++)
    begin
      poll(ST_WANT_BIT, 1'b1);
      wr_reg(REG_DATA, 32'h1000 + i);
    end
    poll(ST_BUSY_BIT, 1'b0);
    chk({24'h0, page_cnt}, 32'h80);
    chk({31'h0, proto_err}, 32'h0);
    chk({24'h0, first_cmd}, 32'h41);
  endtask : t_page
  task automatic t_cmds();
    logic [3:0] ops [8];
    logic [7:0] exp [8];
    ops = '{OP_READ_ARRAY, OP_CLR_STATUS, OP_SUSPEND, OP_RESUME,
            OP_ERASE_ALL, OP_BUF_FLASH, OP_LOAD_BUF, OP_WORD_PROG};
    exp = '{8'hFF, 8'h50, 8'hB0, 8'hD0, 8'hA7, 8'h0E, 8'h74, 8'h40};
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(REG_DATA, 32'hAB12);
      run_op(20'h00010, ops[i]);
      chk({24'h0, first_cmd}, {24'h0, exp[i]});
      repeat (220) @(posedge core_clk);
    end
    stat_bit(ST_REF_BIT, 1'b0);
  endtask : t_cmds
  initial
  begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_ident();
    t_refuse();
    t_erase();
    t_lock();
    t_page();
    t_cmds();
    end_of_test();
  end
endmodule : tb_flash_cmd_host
`default_nettype wire
